/* branch_increment_skip_decode_regs.svh */
// What this block does
// - Long branch loads its 20-bit literal into program counter bits 20..1.
// - Branch first word upper byte 1110 1111; second word upper nibble 1111.
// - Long branch always takes two instruction cycles and changes no flags.
// - Branch: decode Q1, low byte Q2, high bits and counter write Q4.
// - Any literal 0 to 1048575 is accepted, covering the whole program space.
// - Increment adds one to the addressed 8-bit file register value.
// - Destination bit one writes the result back into the source register.
// - Access bit 0 uses the access bank; 1 uses the bank select register.
// - Decrement; continue on zero result, otherwise skip the next instruction.
// - Skip adds one no-operation cycle, two when skipping a long branch, the only two-word instruction decoded.
// - Destination bit zero places the result in the working register.
// - Access 0 with extended set enabled: indexed offset addressing when operand <= 95.
`ifndef BRANCH_INCREMENT_SKIP_DECODE_REGS_SVH
`define BRANCH_INCREMENT_SKIP_DECODE_REGS_SVH

// ==========================================================
// Opcode fields
`define BRANCH_HI_BYTE      8'hef
`define BRANCH_SECOND_NIB   4'hf
`define INC_OPCODE          6'h0a
`define DEC_SKIP_OPCODE     6'h13
`define ACCESS_BIT          8
`define DEST_BIT            9

// ==========================================================
// Addressing
`define INDEXED_LIMIT       8'h5f
`define ACCESS_LOW_LIMIT    8'h60
`define ACCESS_HIGH_BANK    4'hf
`define ACCESS_LOW_BANK     4'h0

// ==========================================================
// Reset values and steps
`define PC_RESET            21'h000000
`define PC_STEP             21'h000002
`define DATA_RESET          8'h00
`define IR_RESET            16'h0000
`define ADDR_RESET          12'h000
`define BYTE_STEP           8'h01

`endif

/* branch_increment_skip_decode_pkg.sv */
`default_nettype none
package branch_increment_skip_decode_pkg;

	// ==========================================================
	// Quarter phases of one instruction cycle
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} phase_t;

	// ==========================================================
	// Cycle kinds
	typedef enum logic [3:0] {
		MODE_EXEC      = 4'h1,
		MODE_BR_NOP    = 4'h2,
		MODE_SKIP_MORE = 4'h4,
		MODE_SKIP_LAST = 4'h8
	} mode_t;

	// ==========================================================
	// Decoded instruction classes
	typedef enum logic [3:0] {
		OP_OTHER  = 4'h1,
		OP_BRANCH = 4'h2,
		OP_INC    = 4'h4,
		OP_DEC_SK = 4'h8
	} op_t;

	typedef struct packed {
		logic [11:0] addr;
		logic        wr_en;
		logic [7:0]  wr_data;
	} file_req_t;

	typedef struct packed {
		logic [3:0]  bank_select_register;
		logic        ext_set_enable;
		logic [11:0] index_base;
	} addr_ctl_t;

	typedef struct packed {
		phase_t      phase;
		mode_t       mode;
		op_t         op;
		logic [15:0] ir;
		logic [7:0]  lit_lo;
		logic [7:0]  operand;
		logic [7:0]  result;
		logic [20:0] pc;
		logic [7:0]  w;
		file_req_t   file;
	} state_t;

endpackage
`default_nettype wire

/* branch_increment_skip_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "branch_increment_skip_decode_regs.svh"

module branch_increment_skip_decode
	import branch_increment_skip_decode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] instr_word,
	input  wire logic [15:0] next_word,
	input  wire logic [7:0]  file_rd_data,
	input  wire addr_ctl_t   addr_ctl,
	output var  file_req_t   file_req,
	output logic [20:0]      pc,
	output logic [7:0]       w_out,
	output logic [3:0]       phase,
	output logic             nop_cycle
);

	// ==========================================================
	// Decoding helpers
	function automatic op_t decode_op(input logic [15:0] word);
		op_t op;
		op = OP_OTHER;
		if (word[15:8] == `BRANCH_HI_BYTE)
		begin
			op = OP_BRANCH;
		end
		else if (word[15:10] == `INC_OPCODE)
		begin
			op = OP_INC;
		end
		else if (word[15:10] == `DEC_SKIP_OPCODE)
		begin
			op = OP_DEC_SK;
		end
		return op;
	endfunction

	// Only the branch opener is known here as a two-word instruction
	function automatic logic is_two_word(input logic [15:0] word);
		return decode_op(word) == OP_BRANCH;
	endfunction

	// Increment and decrement-skip share the read, process and write phases
	function automatic logic reads_file(input op_t op);
		return (op == OP_INC) || (op == OP_DEC_SK);
	endfunction

	function automatic logic [11:0] file_address(
		input logic [15:0] word,
		input addr_ctl_t   ctl
	);
		logic [7:0]  f;
		logic [11:0] addr;
		f = word[7:0];
		if (word[`ACCESS_BIT])
		begin
			addr = {ctl.bank_select_register, f};
		end
		else if (ctl.ext_set_enable && (f <= `INDEXED_LIMIT))
		begin
			addr = ctl.index_base + {4'h0, f};
		end
		else if (f < `ACCESS_LOW_LIMIT)
		begin
			addr = {`ACCESS_LOW_BANK, f};
		end
		else
		begin
			addr = {`ACCESS_HIGH_BANK, f};
		end
		return addr;
	endfunction

	// ==========================================================
	// State
	state_t state_reg;
	state_t state_next;
	op_t    fetched_op;

	assign fetched_op = decode_op(instr_word);

	// ==========================================================
	// Next state, one quarter phase per clock
	always_comb
	begin
		// Every field holds unless its phase below changes it
		state_next = state_reg;
		unique case (state_reg.phase)
			PH_Q1:
			begin
				state_next.phase = PH_Q2;
				if (state_reg.mode == MODE_EXEC)
				begin
					// Only words taken in an execute cycle are decoded
					state_next.ir = instr_word;
					state_next.op = fetched_op;
					state_next.file.addr = file_address(instr_word, addr_ctl);
				end
				else
				begin
					// Words fetched during a no-operation cycle are dropped unseen
					state_next.op = OP_OTHER;
				end
			end
			PH_Q2:
			begin
				state_next.phase = PH_Q3;
				if (state_reg.op == OP_BRANCH)
				begin
					state_next.lit_lo = state_reg.ir[7:0];
				end
				else if (reads_file(state_reg.op))
				begin
					// Address was registered at the Q1 edge, so read data has settled
					state_next.operand = file_rd_data;
				end
			end
			PH_Q3:
			begin
				state_next.phase = PH_Q4;
				// Strobe rises now so the write lands on the edge that closes Q4
				if (state_reg.op == OP_INC)
				begin
					state_next.result = state_reg.operand + `BYTE_STEP;
					state_next.file.wr_data = state_reg.operand + `BYTE_STEP;
					state_next.file.wr_en = state_reg.ir[`DEST_BIT];
				end
				else if (state_reg.op == OP_DEC_SK)
				begin
					state_next.result = state_reg.operand - `BYTE_STEP;
					state_next.file.wr_data = state_reg.operand - `BYTE_STEP;
					state_next.file.wr_en = state_reg.ir[`DEST_BIT];
				end
			end
			PH_Q4:
			begin
				state_next.phase = PH_Q1;
				state_next.file.wr_en = 1'b0;
				// Eight-bit wrap; no status flags are kept by this block
				if (reads_file(state_reg.op) && !state_reg.ir[`DEST_BIT])
				begin
					state_next.w = state_reg.result;
				end
				unique case (state_reg.mode)
					MODE_EXEC:
					begin
						if (state_reg.op == OP_BRANCH)
						begin
							// Second word is consumed here as literal bits 19..8
							state_next.pc = {next_word[11:0], state_reg.lit_lo, 1'b0};
							state_next.mode = MODE_BR_NOP;
						end
						else if (state_reg.op == OP_DEC_SK && state_reg.result != `DATA_RESET)
						begin
							state_next.pc = state_reg.pc + `PC_STEP;
							// The following word is already fetched, so its length is known here
							state_next.mode = is_two_word(next_word) ? MODE_SKIP_MORE : MODE_SKIP_LAST;
						end
						else
						begin
							state_next.pc = state_reg.pc + `PC_STEP;
						end
					end
					MODE_BR_NOP:
					begin
						// Counter already holds the target; nothing else happens
						state_next.mode = MODE_EXEC;
					end
					MODE_SKIP_MORE:
					begin
						// Skipped word was a branch opener; its literal word goes too
						state_next.pc = state_reg.pc + `PC_STEP;
						state_next.mode = MODE_SKIP_LAST;
					end
					MODE_SKIP_LAST:
					begin
						state_next.pc = state_reg.pc + `PC_STEP;
						state_next.mode = MODE_EXEC;
					end
				endcase
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		// Synchronous reset; the counter restarts at word zero
		if (!rst_n)
		begin
			state_reg.phase        <= PH_Q1;
			state_reg.mode         <= MODE_EXEC;
			state_reg.op           <= OP_OTHER;
			state_reg.ir           <= `IR_RESET;
			state_reg.lit_lo       <= `DATA_RESET;
			state_reg.operand      <= `DATA_RESET;
			state_reg.result       <= `DATA_RESET;
			state_reg.pc           <= `PC_RESET;
			state_reg.w            <= `DATA_RESET;
			state_reg.file.addr    <= `ADDR_RESET;
			state_reg.file.wr_en   <= 1'b0;
			state_reg.file.wr_data <= `DATA_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs, all from flops
	assign file_req  = state_reg.file;
	assign pc        = state_reg.pc;
	assign w_out     = state_reg.w;
	assign phase     = state_reg.phase;
	// Decoded from the one-hot mode register, so it stands for whole cycles
	assign nop_cycle = (state_reg.mode != MODE_EXEC);

endmodule
`default_nettype wire

/* bisd_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Program memory and file registers
module bisd_model
	import branch_increment_skip_decode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [20:0] pc,
	input  wire file_req_t   file_req,
	output logic [15:0]      instr_word,
	output logic [15:0]      next_word,
	output logic [7:0]       file_rd_data
);
	logic [15:0] prog [0:15];
	logic [7:0]  fmem [0:4095];
	// Only sixteen words, so far branch targets alias low words
	assign instr_word = prog[pc[4:1]];
	assign next_word = prog[4'(pc[4:1] + 4'h1)];
	assign file_rd_data = fmem[file_req.addr];
	always @(posedge clk)
		if (file_req.wr_en)
			fmem[file_req.addr] <= file_req.wr_data;
endmodule
`default_nettype wire

/* bisd_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module bisd_asserts
	import branch_increment_skip_decode_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [15:0] instr_word,
	input wire logic [15:0] next_word,
	input wire logic [7:0]  file_rd_data,
	input wire addr_ctl_t   addr_ctl,
	input wire file_req_t   file_req,
	input wire logic [20:0] pc,
	input wire logic [3:0]  phase,
	input wire logic        nop_cycle
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [7:0]  lo = instr_word[7:0];
	wire logic [11:0] hk = next_word[11:0];
	wire logic        tk = phase == 4'h1 && !nop_cycle;
	wire logic        inc = tk && instr_word[15:10] == 6'h0a;
	wire logic        dec = tk && instr_word[15:10] == 6'h13;
	wire logic        ix = (inc || dec) && !instr_word[8] && addr_ctl.ext_set_enable && lo <= 8'h5f;
	wire logic        nb = next_word[15:8] == 8'hef;
	sequence br_s;
		tk && instr_word[15:8] == 8'hef;
	endsequence
	// The skip length is known only once Q4 has read the following word
	sequence skip_s;
		dec ##1 file_rd_data != 8'h01 ##2 1'b1;
	endsequence
	chk_br_target: assert property (br_s |-> ##4 pc == {$past(hk), $past(lo, 4), 1'b0})
		else $error("bad target");
	chk_br_nop: assert property (br_s |-> ##4 nop_cycle ##1 (nop_cycle && $stable(pc)) [*3] ##1 !nop_cycle)
		else $error("bad nop");
	chk_wr_pulse: assert property (file_req.wr_en |-> phase == 4'h8 ##1 !file_req.wr_en)
		else $error("bad strobe");
	chk_inc_file: assert property (inc && instr_word[9] |-> ##3 file_req.wr_data == $past(file_rd_data, 2) + 8'h01)
		else $error("bad sum");
	chk_bank_addr: assert property ((inc || dec) && instr_word[8] |=> file_req.addr == {$past(addr_ctl.bank_select_register), $past(lo)})
		else $error("bad bank");
	chk_index_addr: assert property (ix |=> file_req.addr == $past(addr_ctl.index_base) + {4'h0, $past(lo)})
		else $error("bad index");
	chk_skip_one: assert property (skip_s ##0 !nb |-> ##1 nop_cycle [*4] ##1 !nop_cycle)
		else $error("bad skip");
	chk_skip_two: assert property (skip_s ##0 nb |-> ##1 nop_cycle [*8] ##1 !nop_cycle)
		else $error("bad skip2");
endmodule
bind branch_increment_skip_decode bisd_asserts bisd_asserts_i (
	.clk          (clk),
	.rst_n        (rst_n),
	.instr_word   (instr_word),
	.next_word    (next_word),
	.file_rd_data (file_rd_data),
	.addr_ctl     (addr_ctl),
	.file_req     (file_req),
	.pc           (pc),
	.phase        (phase),
	.nop_cycle    (nop_cycle)
);
`default_nettype wire

/* branch_increment_skip_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module branch_increment_skip_decode_tb
	import branch_increment_skip_decode_pkg::*;
;
	logic        clk, rst_n, nop_cycle;
	logic [15:0] instr_word, next_word;
	logic [7:0]  file_rd_data, w_out, v, u;
	logic [20:0] pc;
	logic [3:0]  phase;
	logic [11:0] a0, a1, a2, a3;
	logic [19:0] k;
	addr_ctl_t   addr_ctl;
	file_req_t   file_req;
	integer      err_count, n_compared, seed;
	branch_increment_skip_decode branch_increment_skip_decode_i (
		.clk          (clk),
		.rst_n        (rst_n),
		.instr_word   (instr_word),
		.next_word    (next_word),
		.file_rd_data (file_rd_data),
		.addr_ctl     (addr_ctl),
		.file_req     (file_req),
		.pc           (pc),
		.w_out        (w_out),
		.phase        (phase),
		.nop_cycle    (nop_cycle)
	);
	bisd_model mdl (
		.clk          (clk),
		.pc           (pc),
		.file_req     (file_req),
		.instr_word   (instr_word),
		.next_word    (next_word),
		.file_rd_data (file_rd_data)
	);
	function automatic logic [11:0] addr_of(input logic a, input logic [7:0] f);
		if (a)
			return {addr_ctl.bank_select_register, f};
		if (addr_ctl.ext_set_enable && f <= 8'h5f)
			return addr_ctl.index_base + {4'h0, f};
		return {(f < 8'h60) ? 4'h0 : 4'hf, f};
	endfunction
	task automatic check(input string s, input logic [20:0] e, input logic [20:0] g);
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever
			#2.5 clk = ~clk;
	end
	initial
	begin
		err_count = 0;
		n_compared = 0;
		seed = 75082;
		rst_n = 1'b0;
		addr_ctl = '0;
		for (int r = 0; r < 6; r++)
		begin
			@(posedge clk);
			rst_n <= 1'b0;
			addr_ctl <= {4'($random(seed)), r[0], 8'($random(seed)), 4'h0};
			v = (r == 0) ? 8'hff : 8'($random(seed));
			u = (r == 1) ? 8'hff : 8'($random(seed));
			k = (r == 2) ? 20'hfffff : (r == 3) ? 20'h00000 : 20'($random(seed));
			repeat (20) @(posedge clk);
			// Index base low nibble is zero so the four operands never collide
			a0 = addr_of(1'b0, {r[2], 7'h10});
			a1 = addr_of(1'b1, 8'h23);
			a2 = addr_of(1'b0, 8'h11);
			a3 = addr_of(1'b0, 8'h12);
			// Upper rounds move the first operand into the high half of the access bank
			mdl.prog <= '{{8'h2a, r[2], 7'h10}, 16'h2923, 16'h4e11, 16'h4e12,
				r[1] ? 16'hef00 : 16'h0000, 16'hf000, {8'hef, k[7:0]}, {4'hf, k[19:8]},
				16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
			mdl.fmem[a0] <= v;
			mdl.fmem[a1] <= u;
			mdl.fmem[a2] <= 8'h01;
			mdl.fmem[a3] <= {v[7:1], 1'b0};
			rst_n <= 1'b1;
			repeat (22) @(posedge clk);
			#1;
			check("skip pc", 21'h00000a, pc);
			check("nop", 21'(r[1]), 21'(nop_cycle));
			check("phase", 21'h000004, 21'(phase));
			repeat (8) @(posedge clk);
			#1;
			check("branch pc", {k, 1'b0}, pc);
			check("inc", 8'(v + 8'h01), mdl.fmem[a0]);
			check("bank", u, mdl.fmem[a1]);
			check("w", 8'(u + 8'h01), w_out);
			check("dec", 8'h00, mdl.fmem[a2]);
			check("dec skip", 8'({v[7:1], 1'b0} - 8'h01), mdl.fmem[a3]);
			$display("round %0d done", r);
		end
		complete_run();
	end
endmodule
`default_nettype wire
